/* core/tpoh_clkdiv.sv */
`timescale 1ns/1ps

// divides mclk into the overhead port clock, with edge enables
module tpoh_clkdiv #(
  parameter int HALF = 10
) (
  input  wire logic mclk_i,   // system clock
  input  wire logic srst_i,   // sync reset, active high
  output logic      pclk_o,   // divided port clock level
  output logic      rise_o,   // one-cycle pulse with the rising edge
  output logic      fall_o    // one-cycle pulse with the falling edge
);

  localparam int CW = $clog2(HALF + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
    logic          rise;
    logic          fall;
  } tpoh_div_s;

  tpoh_div_s q;
  tpoh_div_s next_q;

  // toggle every HALF cycles; level starts high so the first edge falls
  always_comb begin
    next_q      = q;
    next_q.rise = 1'b0;
    next_q.fall = 1'b0;
    if (q.cnt == CW'(HALF - 1)) begin
      next_q.cnt  = '0;
      next_q.lvl  = ~q.lvl;
      next_q.rise = ~q.lvl;
      next_q.fall = q.lvl;
    end else begin
      next_q.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q <= '{cnt: '0, lvl: 1'b1, rise: 1'b0, fall: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign pclk_o = q.lvl;
  assign rise_o = q.rise;
  assign fall_o = q.fall;

endmodule : tpoh_clkdiv

/* core/tpoh_insert.sv */
`timescale 1ns/1ps

`include "tpoh_consts.svh"

module tpoh_insert
  import tpoh_pkg::*;
#(
  parameter logic [3:0] CHAN          = 4'h0,                // channel page nibble
  parameter int         FRAME_PERIODS = `TPOH_FRAME_PERIODS  // port periods per SPE
) (
  input  wire logic        mclk_i,                    // 125 MHz system clock
  input  wire logic        srst_i,                    // sync reset, active high
  input  wire logic [15:0] reg_addr_i,                // register byte address
  input  wire logic [7:0]  reg_wdata_i,               // register write data
  input  wire logic        reg_we_i,                  // write strobe
  input  wire logic        reg_re_i,                  // read strobe
  output logic      [7:0]  reg_rdata_o,               // read data, cycle after strobe
  output logic             overhead_port_clock_out_o, // port clock to outside
  output logic             overhead_window_flag_o,    // overhead window flag
  output logic             overhead_frame_flag_o,     // frame start flag
  input  wire logic        overhead_serial_input_i,   // serial overhead bits in
  input  wire logic        overhead_insert_strobe_i,  // per-byte insert request
  output logic      [7:0]  h4_byte_o,                 // H4 byte for the SPE
  output logic      [7:0]  z3_byte_o,                 // Z3 byte for the SPE
  output logic             h4_load_o,                 // pulse, new H4 byte
  output logic             z3_load_o,                 // pulse, new Z3 byte
  output logic             spe_start_o                // pulse, new SPE begins
);

  // port clock half period, derived from the two clock periods
  localparam int LINK_CYC = int'(`TPOH_LINK_NS / `TPOH_MCLK_NS);
  localparam int HALF_CYC = (LINK_CYC / 2 < 1) ? 1 : LINK_CYC / 2;

  tpoh_state_s q;
  tpoh_state_s next_q;

  logic       rise;
  logic       fall;
  logic       pclk;
  logic [7:0] nrc;
  logic       frame_rise;
  logic       take_h4;
  logic       take_z3;
  logic       h4_done;
  logic       z3_done;
  logic       hit;
  logic [7:0] h4_cap;
  logic [7:0] z3_cap;

  // port clock and its edge enables come from one divider on mclk
  tpoh_clkdiv #(
    .HALF   (HALF_CYC)
  ) u_div (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .pclk_o (pclk),
    .rise_o (rise),
    .fall_o (fall)
  );

  // one capture engine per inserted byte
  tpoh_shift #(
    .W      (`TPOH_BYTE_W)
  ) u_h4 (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .clr_i  (frame_rise),
    .take_i (take_h4),
    .bit_i  (q.ser_s),
    .data_o (h4_cap),
    .done_o (h4_done)
  );

  tpoh_shift #(
    .W      (`TPOH_BYTE_W)
  ) u_z3 (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .clr_i  (frame_rise),
    .take_i (take_z3),
    .bit_i  (q.ser_s),
    .data_o (z3_cap),
    .done_o (z3_done)
  );

  // index of the next rising port edge, wrapping once per SPE
  assign nrc = (q.period == 8'(FRAME_PERIODS - 1)) ? 8'h00 : q.period + 8'h01;
  assign frame_rise = rise && (nrc == 8'h00);
  assign hit = (reg_addr_i[15:12] == CHAN);

  // all next-state logic of the block
  always_comb begin
    next_q       = q;
    next_q.rdata = 8'h00;
    next_q.h4_ld = 1'b0;
    next_q.z3_ld = 1'b0;
    next_q.spe   = 1'b0;
    take_h4      = 1'b0;
    take_z3      = 1'b0;

    // pins from the outside pass two flops before anything looks at them
    next_q.ser_m = overhead_serial_input_i;
    next_q.ser_s = q.ser_m;
    next_q.ins_m = overhead_insert_strobe_i;
    next_q.ins_s = q.ins_m;

    // register writes; upper select bits are never stored
    if (reg_we_i && hit) begin
      case (reg_addr_i[11:0])
        `TPOH_OFS_SEL: next_q.sel    = reg_wdata_i & `TPOH_SEL_RW_MASK;
        `TPOH_OFS_H4:  next_q.h4_val = reg_wdata_i;
        `TPOH_OFS_Z3:  next_q.z3_val = reg_wdata_i;
        default:       next_q.sel    = q.sel;
      endcase
    end

    // register reads; data stands one cycle, unmapped reads give zero
    if (reg_re_i && hit) begin
      case (reg_addr_i[11:0])
        `TPOH_OFS_SEL:   next_q.rdata = q.sel;
        `TPOH_OFS_H4:    next_q.rdata = q.h4_val;
        `TPOH_OFS_Z3:    next_q.rdata = q.z3_val;
        `TPOH_OFS_H4_RX: next_q.rdata = q.h4_rx;
        `TPOH_OFS_Z3_RX: next_q.rdata = q.z3_rx;
        default:         next_q.rdata = 8'h00;
      endcase
    end

    // flags change on the falling edge so the outside samples them stable
    if (fall) begin
      next_q.frm = (nrc == 8'h00);
      next_q.win = (nrc < `TPOH_POH_PERIODS);
    end

    // slot tracking on each rising edge
    if (rise) begin
      next_q.period = nrc;
      case (q.st)
        TPOH_ST_HEAD: begin
          if (nrc == `TPOH_H4_WAIT + 8'h01) begin
            next_q.st = TPOH_ST_H4;
          end
        end
        TPOH_ST_H4: begin
          if (nrc == `TPOH_Z3_WAIT + 8'h01) begin
            next_q.st = TPOH_ST_Z3;
          end
        end
        TPOH_ST_Z3: begin
          if (nrc == `TPOH_Z3_WAIT + `TPOH_BYTE_PERIODS + 8'h01) begin
            next_q.st = TPOH_ST_TAIL;
          end
        end
        TPOH_ST_TAIL: begin
          if (nrc == 8'h00) begin
            next_q.st = TPOH_ST_HEAD;
          end
        end
        default: next_q.st = TPOH_ST_HEAD;
      endcase
      if (nrc == 8'h00) begin
        next_q.st = TPOH_ST_HEAD;
      end
    end

    // bits are taken on the rise after the fall that drove them
    take_h4 = rise && (next_q.st == TPOH_ST_H4);
    take_z3 = rise && (next_q.st == TPOH_ST_Z3);

    // the strobe only matters while the matching byte shifts in
    if (take_h4 && q.ins_s) begin
      next_q.h4_ins = 1'b1;
    end
    if (take_z3 && q.ins_s) begin
      next_q.z3_ins = 1'b1;
    end

    // SPE boundary: freeze selects and values for the whole SPE
    if (frame_rise) begin
      next_q.spe     = 1'b1;
      next_q.h4_port = q.sel[`TPOH_BIT_H4];
      next_q.z3_port = q.sel[`TPOH_BIT_Z3];
      next_q.h4_snap = q.h4_val;
      next_q.z3_snap = q.z3_val;
      next_q.h4_ins  = 1'b0;
      next_q.z3_ins  = 1'b0;
      if (!q.sel[`TPOH_BIT_H4]) begin
        next_q.h4_out = q.h4_val;
        next_q.h4_ld  = 1'b1;
      end
      if (!q.sel[`TPOH_BIT_Z3]) begin
        next_q.z3_out = q.z3_val;
        next_q.z3_ld  = 1'b1;
      end
    end

    // a completed port byte replaces the SPE byte when the port is chosen
    if (h4_done) begin
      next_q.h4_rx = h4_cap;
      if (q.h4_port || q.h4_ins) begin
        next_q.h4_out = h4_cap;
        next_q.h4_ld  = 1'b1;
      end
    end
    if (z3_done) begin
      next_q.z3_rx = z3_cap;
      if (q.z3_port || q.z3_ins) begin
        next_q.z3_out = z3_cap;
        next_q.z3_ld  = 1'b1;
      end
    end
  end

  // single state register; period starts at the last index so the
  // first falling edge announces frame 0
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q         <= '0;
      q.sel     <= `TPOH_SEL_RST;
      q.h4_val  <= `TPOH_VAL_RST;
      q.z3_val  <= `TPOH_VAL_RST;
      q.period  <= 8'(FRAME_PERIODS - 1);
      q.st      <= TPOH_ST_TAIL;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata_o               = q.rdata;
  assign overhead_port_clock_out_o = pclk;
  assign overhead_window_flag_o    = q.win;
  assign overhead_frame_flag_o     = q.frm;
  assign h4_byte_o                 = q.h4_out;
  assign z3_byte_o                 = q.z3_out;
  assign h4_load_o                 = q.h4_ld;
  assign z3_load_o                 = q.z3_ld;
  assign spe_start_o               = q.spe;

  // upper select bits can never be seen set
  sel_upper_zero_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    reg_re_i && hit && (reg_addr_i[11:0] == `TPOH_OFS_SEL) |=> reg_rdata_o[7:4] == 4'h0)
    else $error("select register upper bits read non-zero");

  // an H4 value write is stored unchanged in the next cycle
  h4_val_write_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    reg_we_i && hit && (reg_addr_i[11:0] == `TPOH_OFS_H4) |=> q.h4_val == $past(reg_wdata_i))
    else $error("H4 value register did not take the write");

  // a Z3 value write is stored unchanged
  z3_val_write_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    reg_we_i && hit && (reg_addr_i[11:0] == `TPOH_OFS_Z3) |=> q.z3_val == $past(reg_wdata_i))
    else $error("Z3 value register did not take the write");

  // software-sourced H4 is the frozen register value at each SPE start
  h4_soft_src_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    spe_start_o && !q.h4_port |-> h4_load_o && (h4_byte_o == q.h4_snap))
    else $error("H4 byte not taken from software value");

  // software-sourced Z3 likewise
  z3_soft_src_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    spe_start_o && !q.z3_port |-> z3_load_o && (z3_byte_o == q.z3_snap))
    else $error("Z3 byte not taken from software value");

  // port-sourced H4 equals the byte just shifted in
  h4_port_src_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    h4_done && q.h4_port |=> h4_load_o && (h4_byte_o == $past(h4_cap)))
    else $error("H4 byte not taken from the port");

  // port-sourced Z3 equals the byte just shifted in
  z3_port_src_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    z3_done && q.z3_port |=> z3_load_o && (z3_byte_o == $past(z3_cap)))
    else $error("Z3 byte not taken from the port");

  // capture only on a rising port edge, with the port clock just gone high
  capture_edge_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (take_h4 || take_z3) |-> overhead_port_clock_out_o && $rose(overhead_port_clock_out_o))
    else $error("serial bit taken away from a rising port edge");

  // the H4 bits start five byte times after the flagged edge
  h4_slot_pos_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    $rose(q.st == TPOH_ST_H4) |-> q.period == `TPOH_H4_WAIT + 8'h01)
    else $error("H4 slot does not start after the sixth byte wait");

  // Z3 bits start one byte time after the H4 bits
  z3_slot_pos_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    $rose(q.st == TPOH_ST_Z3) |-> q.period == `TPOH_Z3_WAIT + 8'h01)
    else $error("Z3 slot does not start after the seventh byte wait");

  // the eighth H4 bit lands on the last rise of the H4 slot
  h4_byte_end_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    h4_done |-> q.period == `TPOH_H4_WAIT + `TPOH_BYTE_PERIODS)
    else $error("H4 byte completed on the wrong port edge");

  // the eighth Z3 bit lands on the last rise of the Z3 slot
  z3_byte_end_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    z3_done |-> q.period == `TPOH_Z3_WAIT + `TPOH_BYTE_PERIODS)
    else $error("Z3 byte completed on the wrong port edge");

  // an H4 byte changes only at an SPE start or after a whole port byte
  h4_load_when_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    h4_load_o |-> spe_start_o || $past(h4_done))
    else $error("H4 byte changed inside an SPE");

  // a Z3 byte changes only at an SPE start or after a whole port byte
  z3_load_when_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    z3_load_o |-> spe_start_o || $past(z3_done))
    else $error("Z3 byte changed inside an SPE");

  // both flags stand high at the SPE start, so the outside counts from here
  spe_flags_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    spe_start_o |-> overhead_frame_flag_o && overhead_window_flag_o)
    else $error("flags not both high at the SPE start");

  // frozen value stays put between SPE starts
  snap_hold_a: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    !frame_rise |=> $stable(q.h4_snap) && $stable(q.z3_snap))
    else $error("software value changed inside an SPE");

endmodule : tpoh_insert

/* core/tpoh_shift.sv */
`timescale 1ns/1ps

// msb-first serial to parallel capture of one overhead byte
module tpoh_shift #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,  // system clock
  input  wire logic         srst_i,  // sync reset, active high
  input  wire logic         clr_i,   // restart the bit count
  input  wire logic         take_i,  // shift one bit in
  input  wire logic         bit_i,   // serial data, already synchronised
  output logic [W-1:0]      data_o,  // last complete byte
  output logic              done_o   // pulse after the last bit
);

  localparam int CW = $clog2(W + 1);

  typedef struct packed {
    logic [W-1:0]  data;
    logic [W-1:0]  sh;
    logic [CW-1:0] cnt;
    logic          done;
  } tpoh_sh_s;

  tpoh_sh_s q;
  tpoh_sh_s next_q;

  // a clear restarts a torn byte so one late frame cannot shift the next
  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    if (clr_i) begin
      next_q.cnt = '0;
    end else if (take_i) begin
      next_q.sh = {q.sh[W-2:0], bit_i};
      if (q.cnt == CW'(W - 1)) begin
        next_q.data = {q.sh[W-2:0], bit_i};
        next_q.done = 1'b1;
        next_q.cnt  = '0;
      end else begin
        next_q.cnt = q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign data_o = q.data;
  assign done_o = q.done;

endmodule : tpoh_shift

/* inc/tpoh_consts.svh */
`ifndef TPOH_CONSTS_SVH
`define TPOH_CONSTS_SVH

// register offsets inside one channel page, channel nibble on top
`define TPOH_OFS_SEL      12'h982
`define TPOH_OFS_H4       12'h9A7
`define TPOH_OFS_Z3       12'h9AB
`define TPOH_OFS_H4_RX    12'h9B0
`define TPOH_OFS_Z3_RX    12'h9B4

// reset values and field layout
`define TPOH_SEL_RST      8'h00
`define TPOH_SEL_RW_MASK  8'h0F
`define TPOH_VAL_RST      8'h00
`define TPOH_BIT_H4       0
`define TPOH_BIT_Z3       1

// overhead port timing, counted in port clock periods
`define TPOH_H4_WAIT      8'h28
`define TPOH_Z3_WAIT      8'h30
`define TPOH_BYTE_W       8
`define TPOH_BYTE_PERIODS 8'h08
`define TPOH_POH_PERIODS  8'h48
`define TPOH_FRAME_PERIODS 96

// clock periods in ns
`define TPOH_MCLK_NS      32'h8
`define TPOH_LINK_NS      32'hA0

`endif

/* inc/tpoh_pkg.sv */
package tpoh_pkg;

  // slot of the overhead sequence the port is in
  typedef enum logic [3:0] {
    TPOH_ST_HEAD = 4'h1,
    TPOH_ST_H4   = 4'h2,
    TPOH_ST_Z3   = 4'h4,
    TPOH_ST_TAIL = 4'h8
  } tpoh_st_e;

  typedef logic [7:0] tpoh_byte_t;

  // whole state of the insert block
  typedef struct packed {
    tpoh_byte_t sel;
    tpoh_byte_t h4_val;
    tpoh_byte_t z3_val;
    tpoh_byte_t rdata;
    logic       ser_m;
    logic       ser_s;
    logic       ins_m;
    logic       ins_s;
    tpoh_byte_t period;
    tpoh_st_e   st;
    logic       win;
    logic       frm;
    logic       h4_port;
    logic       z3_port;
    tpoh_byte_t h4_snap;
    tpoh_byte_t z3_snap;
    logic       h4_ins;
    logic       z3_ins;
    tpoh_byte_t h4_out;
    tpoh_byte_t z3_out;
    logic       h4_ld;
    logic       z3_ld;
    logic       spe;
    tpoh_byte_t h4_rx;
    tpoh_byte_t z3_rx;
  } tpoh_state_s;

endpackage : tpoh_pkg

/* test/tpoh_far_model.sv */
`timescale 1ns/1ps

// outside insertion circuit: watches the flags, waits, then shifts the h4 and z3 bytes in msb first
module tpoh_far_model (
  input  wire logic       pclk_i,   // port clock from the device
  input  wire logic       win_i,    // window flag from the device
  input  wire logic       frm_i,    // frame flag from the device
  input  wire logic       h4_en_i,  // shift an h4 byte each frame
  input  wire logic       z3_en_i,  // shift a z3 byte each frame
  input  wire logic [7:0] h4_i,     // h4 byte to send
  input  wire logic [7:0] z3_i,     // z3 byte to send
  output logic            ser_o     // serial overhead bit to the device
);
  int   idx = 1000;
  logic ser = 1'b0;

  assign ser_o = ser;

  // flags are looked at on rising port edges only; both high restarts the count
  always @(posedge pclk_i) begin
    if (win_i === 1'b1 && frm_i === 1'b1) begin
      idx = 0;
    end else if (idx < 1000) begin
      idx = idx + 1;
    end
  end

  // bits change on falling edges; idle slots toggle so a stale bit never looks right
  always @(negedge pclk_i) begin
    if (h4_en_i && idx >= 40 && idx <= 47) begin
      ser <= h4_i[47 - idx];
    end else if (z3_en_i && idx >= 48 && idx <= 55) begin
      ser <= z3_i[55 - idx];
    end else begin
      ser <= ~ser;
    end
  end
endmodule : tpoh_far_model

/* test/tx_path_overhead_h4_z3_insert_bench.sv */
`timescale 1ns/1ps

`include "tpoh_consts.svh"

module tx_path_overhead_h4_z3_insert_bench;
  import tpoh_pkg::*;

  localparam logic [3:0] CHAN = 4'h2;
  localparam int         NPER = 80;  // short spe keeps the run brief

  logic        mclk, srst, we, re, ins, ser, pclk, win, frm;
  logic        h4_ld, z3_ld, spe;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, h4_b, z3_b, rd;
  tpoh_byte_t  far_h4, far_z3;
  int          fail_count, samples_checked;

  tpoh_insert #(.CHAN(CHAN), .FRAME_PERIODS(NPER)) dut (
    .mclk_i(mclk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .overhead_port_clock_out_o(pclk), .overhead_window_flag_o(win),
    .overhead_frame_flag_o(frm), .overhead_serial_input_i(ser),
    .overhead_insert_strobe_i(ins), .h4_byte_o(h4_b), .z3_byte_o(z3_b),
    .h4_load_o(h4_ld), .z3_load_o(z3_ld), .spe_start_o(spe)
  );

  tpoh_far_model far (
    .pclk_i(pclk), .win_i(win), .frm_i(frm), .h4_en_i(1'b1), .z3_en_i(1'b1),
    .h4_i(far_h4), .z3_i(far_z3), .ser_o(ser)
  );

  // 125 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic test_done;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  task automatic reg_wr(input logic [3:0] ch, input logic [11:0] ofs, input logic [7:0] d);
    @(posedge mclk);
    we    <= 1'b1;
    addr  <= {ch, ofs};
    wdata <= d;
    @(posedge mclk);
    we    <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [11:0] ofs, output logic [7:0] d);
    @(posedge mclk);
    re   <= 1'b1;
    addr <= {CHAN, ofs};
    @(posedge mclk);
    re   <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // which: 0 spe start, 1 h4 load, 2 z3 load; bounded by two spe lengths
  task automatic wait_pulse(input int which);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 2 * NPER * 20 && !hit; i++) begin
      @(posedge mclk);
      hit = (which == 0) ? (spe === 1'b1) : (which == 1) ? (h4_ld === 1'b1) : (z3_ld === 1'b1);
    end
    if (!hit) begin
      fail_count++;
      $display("wrong value pulse %0d expected 1 seen 0", which);
    end
  endtask : wait_pulse

  task automatic t_regs;
    reg_rd(`TPOH_OFS_SEL, rd);
    check8("select reset", `TPOH_SEL_RST, rd);
    reg_rd(`TPOH_OFS_H4, rd);
    check8("h4 reset", `TPOH_VAL_RST, rd);
    reg_rd(`TPOH_OFS_Z3, rd);
    check8("z3 reset", `TPOH_VAL_RST, rd);
    reg_wr(CHAN, `TPOH_OFS_SEL, 8'hFF);
    reg_rd(`TPOH_OFS_SEL, rd);
    check8("select mask", 8'h0F, rd);
    reg_wr(CHAN, `TPOH_OFS_H4, 8'h5A);
    reg_wr(CHAN, `TPOH_OFS_Z3, 8'hA5);
    reg_wr(4'h5, `TPOH_OFS_H4, 8'hFF);
    reg_rd(`TPOH_OFS_H4, rd);
    check8("h4 rw", 8'h5A, rd);
    reg_rd(`TPOH_OFS_Z3, rd);
    check8("z3 rw", 8'hA5, rd);
    reg_rd(12'h9A0, rd);
    check8("unmapped", 8'h00, rd);
    reg_wr(CHAN, `TPOH_OFS_SEL, 8'h00);
  endtask : t_regs

  // flags as the outside sees them: at the spe start, just after, and past the window
  task automatic t_flags;
    wait_pulse(0);
    check8("flags at spe", 8'h03, {6'h00, win, frm});
    repeat (40) @(posedge mclk);
    check8("flags after", 8'h02, {6'h00, win, frm});
    repeat (1500) @(posedge mclk);
    check8("flags late", 8'h00, {6'h00, win, frm});
  endtask : t_flags

  task automatic t_soft;
    reg_wr(CHAN, `TPOH_OFS_H4, 8'h66);
    reg_wr(CHAN, `TPOH_OFS_Z3, 8'h99);
    wait_pulse(0);
    wait_pulse(0);
    repeat (4) @(posedge mclk);
    check8("soft h4", 8'h66, h4_b);
    check8("soft z3", 8'h99, z3_b);
  endtask : t_soft

  // a write in mid-spe must not reach the byte until the next spe
  task automatic t_mid;
    wait_pulse(0);
    reg_wr(CHAN, `TPOH_OFS_H4, 8'h11);
    repeat (800) @(posedge mclk);
    check8("h4 held", 8'h66, h4_b);
    wait_pulse(0);
    repeat (4) @(posedge mclk);
    check8("h4 next spe", 8'h11, h4_b);
  endtask : t_mid

  task automatic t_port;
    far_h4 = 8'hC3;
    far_z3 = 8'h81;
    reg_wr(CHAN, `TPOH_OFS_SEL, 8'h01);
    wait_pulse(0);
    wait_pulse(1);
    check8("port h4", 8'hC3, h4_b);
    check8("soft z3 kept", 8'h99, z3_b);
    far_h4 = 8'h96;
    reg_wr(CHAN, `TPOH_OFS_SEL, 8'h03);
    wait_pulse(0);
    wait_pulse(1);
    check8("port h4 again", 8'h96, h4_b);
    wait_pulse(2);
    check8("port z3", 8'h81, z3_b);
    reg_rd(`TPOH_OFS_H4_RX, rd);
    check8("h4 captured", 8'h96, rd);
    reg_rd(`TPOH_OFS_Z3_RX, rd);
    check8("z3 captured", 8'h81, rd);
  endtask : t_port

  task automatic t_back;
    reg_wr(CHAN, `TPOH_OFS_SEL, 8'h00);
    wait_pulse(0);
    wait_pulse(0);
    repeat (4) @(posedge mclk);
    check8("back h4", 8'h11, h4_b);
    check8("back z3", 8'h99, z3_b);
  endtask : t_back

  // the insert strobe takes the port byte for one spe with both selects clear
  task automatic t_strobe;
    ins <= 1'b1;
    wait_pulse(0);
    wait_pulse(1);
    check8("strobe h4", 8'h96, h4_b);
    wait_pulse(2);
    check8("strobe z3", 8'h81, z3_b);
    ins <= 1'b0;
    wait_pulse(0);
    repeat (4) @(posedge mclk);
    check8("strobe off h4", 8'h11, h4_b);
    check8("strobe off z3", 8'h99, z3_b);
  endtask : t_strobe

  // watchdog: the sequence needs about a dozen spe lengths
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    test_done();
  end

  initial begin
    fail_count      = 0;
    samples_checked = 0;
    srst   = 1'b1;
    we     = 1'b0;
    re     = 1'b0;
    ins    = 1'b0;
    addr   = 16'h0000;
    wdata  = 8'h00;
    far_h4 = 8'h00;
    far_z3 = 8'h00;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_flags();
    t_soft();
    t_mid();
    t_port();
    t_back();
    t_strobe();
    test_done();
  end
endmodule : tx_path_overhead_h4_z3_insert_bench
